// >>> src/stc_device.sv
`timescale 1ns/1ps
// How it works
// - reset held after power-up, selected delay
// - watchdog period from selector, 11 off
// - fault held 200 ms, selectors 00/01
// - fault held 25 ms, selector 10
// - host restart pulse at least 1 us
// - self-timed write after write stop
// - host waits full write time after stop
// - reset asserted within 5 us of fall
// - serial pulses under 50 ns ignored
// - program 10 ms, then 1 ms off
// - programming voltage 10 us around action
module stc_device #(
  // cycle counts, shortenable for simulation
  parameter int P_POR0 = stc_pkg::POR_C0,
  parameter int P_POR1 = stc_pkg::POR_C1,
  parameter int P_POR2 = stc_pkg::POR_C2,
  parameter int P_POR3 = stc_pkg::POR_C3,
  parameter int P_WD0 = stc_pkg::WD_C0,
  parameter int P_WD1 = stc_pkg::WD_C1,
  parameter int P_WD2 = stc_pkg::WD_C2,
  parameter int P_WDT1 = stc_pkg::WD_T1_C,
  parameter int P_WDT2 = stc_pkg::WD_T2_C,
  parameter int P_NVW = stc_pkg::NVW_C
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link to host
  stc_link_if.dev link,
  // selector bits from the nonvolatile control register
  input wire logic por_delay_sel_hi,
  input wire logic por_delay_sel_lo,
  input wire logic wdog_period_sel_hi,
  input wire logic wdog_period_sel_lo,
  // supply comparators, high while below trip
  input wire logic primary_below_trip,
  input wire logic second_supply_sense,
  // memory side
  input wire logic nv_write_req,
  output logic nv_busy
);
  import stc_pkg::*;

  // refuse counts the counters cannot hold
  if (P_POR0 < 1 || P_POR1 < 1 || P_POR2 < 1 || P_POR3 < 1 || P_WD0 < 1 || P_WD1 < 1 ||
      P_WD2 < 1 || P_WDT1 < 1 || P_WDT2 < 1 || P_NVW < 1) begin : g_chk_min
    $error("stc_device: every count must be at least one cycle");
  end
  if (P_WD0 >= (1 << CW) || P_POR3 >= (1 << CW)) begin : g_chk_max
    $error("stc_device: count too wide for counter");
  end
  if (GLITCH_CYC > 4 || RSP_CYC > 254 || TRP_USED > TRP_CYC) begin : g_chk_fix
    $error("stc_device: fixed timing out of range");
  end

  localparam logic [1:0] FLT_LAST = 2'(GLITCH_CYC - 1);
  localparam logic [7:0] RSP_LAST = 8'(RSP_CYC - 1);

  // pins in: scl, sda, restart, primary, second
  logic [4:0] pin_raw;
  logic [4:0] sy1_r;
  logic [4:0] sy1_nxt;
  logic [4:0] sy2_r;
  logic [4:0] sy2_nxt;
  assign pin_raw = {second_supply_sense, primary_below_trip, link.wdog_restart,
                    link.sda, link.scl};

  // two-stage synchroniser
  always_comb begin
    sy1_nxt = pin_raw;
    sy2_nxt = sy1_r;
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sy1_r <= SYNC_RST;
      sy2_r <= SYNC_RST;
    end else begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
    end
  end

  // filtered scl and sda
  logic [1:0] bus_f;
  for (genvar gi = 0; gi < 2; gi++) begin : g_flt
    logic [1:0] cnt_r;
    logic [1:0] cnt_nxt;
    logic lvl_r;
    logic lvl_nxt;
    // a new level is taken only after it stands long enough
    always_comb begin
      cnt_nxt = 2'h0;
      lvl_nxt = lvl_r;
      if (sy2_r[gi] != lvl_r) begin
        if (cnt_r == FLT_LAST) begin
          lvl_nxt = sy2_r[gi];
        end else begin
          cnt_nxt = cnt_r + 2'h1;
        end
      end
    end
    always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
        cnt_r <= 2'h0;
        lvl_r <= 1'b1;
      end else begin
        cnt_r <= cnt_nxt;
        lvl_r <= lvl_nxt;
      end
    end
    assign bus_f[gi] = lvl_r;
  end

  // serial framing and write cycle
  logic [1:0] bus_q_r;
  logic [1:0] bus_q_nxt;
  logic frame_r;
  logic frame_nxt;
  logic [CW-1:0] nv_cnt_r;
  logic [CW-1:0] nv_cnt_nxt;
  logic nv_busy_r;
  logic nv_busy_nxt;
  logic bus_start;
  logic bus_stop;

  // start and stop: sda moves while scl stays high
  always_comb begin
    bus_start = bus_q_r[0] & bus_f[0] & bus_q_r[1] & ~bus_f[1];
    bus_stop = bus_q_r[0] & bus_f[0] & ~bus_q_r[1] & bus_f[1];
    bus_q_nxt = bus_f;
    frame_nxt = frame_r;
    nv_cnt_nxt = nv_cnt_r;
    nv_busy_nxt = nv_busy_r;
    if (bus_start) begin
      frame_nxt = 1'b1;
    end else if (bus_stop) begin
      frame_nxt = 1'b0;
    end
    if (nv_busy_r) begin
      // self-timed write runs to its end
      if (nv_cnt_r == CW'(P_NVW - 1)) begin
        nv_busy_nxt = 1'b0;
        nv_cnt_nxt = '0;
      end else begin
        nv_cnt_nxt = nv_cnt_r + 1'b1;
      end
    end else if (bus_stop && frame_r && nv_write_req) begin
      nv_busy_nxt = 1'b1;
      nv_cnt_nxt = '0;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_q_r <= 2'h3;
      frame_r <= 1'b0;
      nv_cnt_r <= '0;
      nv_busy_r <= 1'b0;
    end else begin
      bus_q_r <= bus_q_nxt;
      frame_r <= frame_nxt;
      nv_cnt_r <= nv_cnt_nxt;
      nv_busy_r <= nv_busy_nxt;
    end
  end
  assign nv_busy = nv_busy_r;

  // power-on and low-supply reset
  stc_por_state_type pr_r;
  stc_por_state_type pr_nxt;
  logic [CW-1:0] pr_cnt_r;
  logic [CW-1:0] pr_cnt_nxt;
  logic [CW-1:0] por_tgt;
  logic rst_out_r;
  logic rst_out_nxt;
  logic v2f_r;
  logic v2f_nxt;

  // delay selection, last count of the hold
  always_comb begin
    unique case ({por_delay_sel_hi, por_delay_sel_lo})
      2'h0: por_tgt = CW'(P_POR0 - 1);
      2'h1: por_tgt = CW'(P_POR1 - 1);
      2'h2: por_tgt = CW'(P_POR2 - 1);
      2'h3: por_tgt = CW'(P_POR3 - 1);
    endcase
  end

  // hold while low, then count the delay out
  always_comb begin
    pr_nxt = pr_r;
    pr_cnt_nxt = '0;
    unique case (pr_r)
      PR_HOLD: begin
        if (!sy2_r[3]) begin
          pr_nxt = PR_DELAY;
        end
      end
      PR_DELAY: begin
        if (sy2_r[3]) begin
          pr_nxt = PR_HOLD;
        end else if (pr_cnt_r >= por_tgt) begin
          pr_nxt = PR_RUN;
        end else begin
          pr_cnt_nxt = pr_cnt_r + 1'b1;
        end
      end
      PR_RUN: begin
        if (sy2_r[3]) begin
          pr_nxt = PR_HOLD;
        end
      end
    endcase
    rst_out_nxt = (pr_nxt != PR_RUN);
    v2f_nxt = sy2_r[4];
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pr_r <= PR_HOLD;
      pr_cnt_r <= '0;
      rst_out_r <= 1'b1;
      v2f_r <= 1'b0;
    end else begin
      pr_r <= pr_nxt;
      pr_cnt_r <= pr_cnt_nxt;
      rst_out_r <= rst_out_nxt;
      v2f_r <= v2f_nxt;
    end
  end

  // restart recognition, counts a pulse's high samples
  logic [7:0] rs_cnt_r;
  logic [7:0] rs_cnt_nxt;
  logic rs_evt;
  always_comb begin
    rs_evt = sy2_r[2] && (rs_cnt_r == RSP_LAST);
    rs_cnt_nxt = '0;
    if (sy2_r[2]) begin
      rs_cnt_nxt = (rs_cnt_r > RSP_LAST) ? rs_cnt_r : rs_cnt_r + 8'h01;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs_cnt_r <= '0;
    end else begin
      rs_cnt_r <= rs_cnt_nxt;
    end
  end

  // watchdog period and fault hold
  stc_wd_state_type wd_r;
  stc_wd_state_type wd_nxt;
  logic [CW-1:0] wd_cnt_r;
  logic [CW-1:0] wd_cnt_nxt;
  logic [CW-1:0] wd_tgt;
  logic [CW-1:0] wd_hold;
  logic [1:0] wd_sel;
  logic wdf_r;
  logic wdf_nxt;
  assign wd_sel = {wdog_period_sel_hi, wdog_period_sel_lo};

  // period and hold for the selected setting
  always_comb begin
    unique case (wd_sel)
      2'h0: wd_tgt = CW'(P_WD0 - 1);
      2'h1: wd_tgt = CW'(P_WD1 - 1);
      2'h2: wd_tgt = CW'(P_WD2 - 1);
      2'h3: wd_tgt = '0;
    endcase
    wd_hold = (wd_sel == WD_SEL_P2) ? CW'(P_WDT2 - 1) : CW'(P_WDT1 - 1);
  end

  // off or in reset: idle; run counts; fault holds
  always_comb begin
    wd_nxt = wd_r;
    wd_cnt_nxt = wd_cnt_r + 1'b1;
    if (wd_sel == WD_SEL_OFF || rst_out_r) begin
      wd_nxt = WD_IDLE;
      wd_cnt_nxt = '0;
    end else begin
      unique case (wd_r)
        WD_IDLE: begin
          wd_nxt = WD_RUN;
          wd_cnt_nxt = '0;
        end
        WD_RUN: begin
          if (rs_evt) begin
            wd_cnt_nxt = '0;
          end else if (wd_cnt_r >= wd_tgt) begin
            wd_nxt = WD_FAULT;
            wd_cnt_nxt = '0;
          end
        end
        WD_FAULT: begin
          if (wd_cnt_r >= wd_hold) begin
            wd_nxt = WD_RUN;
            wd_cnt_nxt = '0;
          end
        end
      endcase
    end
    wdf_nxt = (wd_nxt == WD_FAULT);
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wd_r <= WD_IDLE;
      wd_cnt_r <= '0;
      wdf_r <= 1'b0;
    end else begin
      wd_r <= wd_nxt;
      wd_cnt_r <= wd_cnt_nxt;
      wdf_r <= wdf_nxt;
    end
  end

  // link outputs from flops
  assign link.reset_out = rst_out_r;
  assign link.wdog_fault_out = wdf_r;
  assign link.second_supply_fail_out = v2f_r;
endmodule : stc_device

// >>> src/stc_host.sv
`timescale 1ns/1ps
module stc_host #(
  // cycle counts, shortenable for simulation
  parameter int P_NVG = stc_pkg::NVW_MAX_C,
  parameter int P_PRG = stc_pkg::PRG_C,
  parameter int P_VPO = stc_pkg::VPO_C
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [stc_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // interrupt
  output logic irq,
  // link to device
  stc_link_if.host link
);
  import stc_pkg::*;

  // refuse counts the counter cannot hold
  if (P_NVG < 1 || P_PRG < 1 || P_VPO < 1 || P_NVG >= (1 << CW) ||
      P_PRG >= (1 << CW)) begin : g_chk
    $error("stc_host: count out of range");
  end

  // bus decode, zero wait states
  logic wr_acc;
  logic ctrl_wr;
  logic bus_wr;
  logic nvg_busy;
  logic rs_busy;
  logic pg_busy;
  logic prog_done;
  assign wr_acc = psel & penable & pwrite;
  assign ctrl_wr = wr_acc & (paddr == RG_CTRL);
  assign bus_wr = wr_acc & (paddr == RG_BUS);
  assign pready = 1'b1;

  // registers and events
  logic [2:0] bus_r;
  logic [2:0] bus_nxt;
  logic [NEV-1:0] st_r;
  logic [NEV-1:0] st_nxt;
  logic [NEV-1:0] mask_r;
  logic [NEV-1:0] mask_nxt;
  logic [NEV-1:0] ev;
  logic [2:0] lvl_q_r;
  logic [31:0] prd_r;
  logic [31:0] prd_nxt;
  logic err_r;
  logic err_nxt;
  logic irq_r;
  logic irq_nxt;
  logic bus_stop_wr;
  logic [2:0] lvl;
  assign lvl = {link.second_supply_fail_out, link.wdog_fault_out, link.reset_out};

  // register writes, sticky status with set over clear
  always_comb begin
    bus_stop_wr = bus_wr & ~nvg_busy & bus_r[BUS_SCL] & pwdata[BUS_SCL] & ~bus_r[BUS_SDA] &
                  pwdata[BUS_SDA] & pwdata[BUS_WRM];
    ev[2:0] = lvl & ~lvl_q_r;
    ev[3] = prog_done;
    ev[4] = (bus_wr & nvg_busy) | (ctrl_wr & pwdata[CT_RST] & rs_busy) |
            (ctrl_wr & pwdata[CT_PRG] & pg_busy);
    bus_nxt = (bus_wr && !nvg_busy) ? pwdata[2:0] : bus_r;
    mask_nxt = (wr_acc && paddr == RG_MASK) ? pwdata[NEV-1:0] : mask_r;
    st_nxt = st_r;
    if (wr_acc && paddr == RG_STAT) begin
      st_nxt = st_r & ~pwdata[NEV-1:0];
    end
    st_nxt = st_nxt | ev;
    irq_nxt = |(st_nxt & mask_nxt);
    prd_nxt = prd_r;
    err_nxt = 1'b0;
    if (psel && !penable) begin
      err_nxt = 1'b0;
      unique case (paddr)
        RG_CTRL: prd_nxt = '0;
        RG_BUS: prd_nxt = {29'h0, bus_r};
        RG_STAT: prd_nxt = {27'h0, st_r};
        RG_MASK: prd_nxt = {27'h0, mask_r};
        RG_LEVEL: prd_nxt = {26'h0, pg_busy, nvg_busy, rs_busy, lvl};
        default: begin
          prd_nxt = '0;
          err_nxt = 1'b1;
        end
      endcase
    end else if (psel) begin
      err_nxt = err_r;
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      bus_r <= BUS_RST;
      st_r <= '0;
      mask_r <= '0;
      lvl_q_r <= 3'h1;
      prd_r <= '0;
      err_r <= 1'b0;
      irq_r <= 1'b0;
    end else begin
      bus_r <= bus_nxt;
      st_r <= st_nxt;
      mask_r <= mask_nxt;
      lvl_q_r <= lvl;
      prd_r <= prd_nxt;
      err_r <= err_nxt;
      irq_r <= irq_nxt;
    end
  end
  assign prdata = prd_r;
  assign pslverr = err_r & penable;
  assign irq = irq_r;
  assign link.scl_oe = ~bus_r[BUS_SCL];
  assign link.sda_oe = ~bus_r[BUS_SDA];

  // restart pulse and write-cycle guard
  logic [7:0] rs_cnt_r;
  logic [7:0] rs_cnt_nxt;
  logic [CW-1:0] nvg_cnt_r;
  logic [CW-1:0] nvg_cnt_nxt;
  assign rs_busy = (rs_cnt_r != 8'h00);
  assign nvg_busy = (nvg_cnt_r != '0);
  always_comb begin
    rs_cnt_nxt = rs_busy ? rs_cnt_r - 8'h01 : rs_cnt_r;
    if (ctrl_wr && pwdata[CT_RST] && !rs_busy) begin
      rs_cnt_nxt = 8'(RSP_CYC);
    end
    nvg_cnt_nxt = nvg_busy ? nvg_cnt_r - 1'b1 : nvg_cnt_r;
    if (bus_stop_wr) begin
      nvg_cnt_nxt = CW'(P_NVG);
    end
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rs_cnt_r <= '0;
      nvg_cnt_r <= '0;
    end else begin
      rs_cnt_r <= rs_cnt_nxt;
      nvg_cnt_r <= nvg_cnt_nxt;
    end
  end
  assign link.wdog_restart = rs_busy;

  // threshold programming sequence
  stc_prog_state_type pg_r;
  stc_prog_state_type pg_nxt;
  logic [CW-1:0] pg_cnt_r;
  logic [CW-1:0] pg_cnt_nxt;
  assign pg_busy = (pg_r != PG_IDLE);
  always_comb begin
    pg_nxt = pg_r;
    pg_cnt_nxt = pg_cnt_r + 1'b1;
    prog_done = 1'b0;
    unique case (pg_r)
      PG_IDLE: begin
        pg_cnt_nxt = '0;
        if (ctrl_wr && pwdata[CT_PRG]) begin
          pg_nxt = PG_SETUP;
        end
      end
      PG_SETUP: begin
        if (pg_cnt_r == CW'(VPS_C - 1)) begin
          pg_nxt = PG_PROG;
          pg_cnt_nxt = '0;
        end
      end
      PG_PROG: begin
        if (pg_cnt_r == CW'(P_PRG - 1)) begin
          pg_nxt = PG_HOLD;
          pg_cnt_nxt = '0;
        end
      end
      PG_HOLD: begin
        if (pg_cnt_r == CW'(VPH_C - 1)) begin
          pg_nxt = PG_OFF;
          pg_cnt_nxt = '0;
        end
      end
      PG_OFF: begin
        if (pg_cnt_r == CW'(P_VPO - 1)) begin
          pg_nxt = PG_IDLE;
          prog_done = 1'b1;
        end
      end
    endcase
  end
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pg_r <= PG_IDLE;
      pg_cnt_r <= '0;
    end else begin
      pg_r <= pg_nxt;
      pg_cnt_r <= pg_cnt_nxt;
    end
  end
  assign link.prog_vp = (pg_r == PG_SETUP) | (pg_r == PG_PROG) | (pg_r == PG_HOLD);
  assign link.prog_strobe = (pg_r == PG_PROG);
endmodule : stc_host

// >>> src/stc_link_if.sv
`timescale 1ns/1ps
interface stc_link_if;
  // open-drain enables, high pulls the line low
  logic scl_oe;
  logic sda_oe;
  // resolved bus levels
  logic scl;
  logic sda;
  // host to device
  logic wdog_restart;
  logic prog_vp;
  logic prog_strobe;
  // device to host, high means active
  logic reset_out;
  logic wdog_fault_out;
  logic second_supply_fail_out;
  // pulled-up wires
  assign scl = ~scl_oe;
  assign sda = ~sda_oe;
  modport dev (
    input scl, input sda, input wdog_restart, input prog_vp, input prog_strobe,
    output reset_out, output wdog_fault_out, output second_supply_fail_out
  );
  modport host (
    output scl_oe, output sda_oe, input scl, input sda,
    output wdog_restart, output prog_vp, output prog_strobe,
    input reset_out, input wdog_fault_out, input second_supply_fail_out
  );
endinterface : stc_link_if

// >>> src/stc_pkg.sv
package stc_pkg;
  // clock rate
  localparam int CLK_HZ = 40_000_000;
  localparam int CLK_PER_NS = 25;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  localparam int CYC_PER_US = CLK_HZ / 1_000_000;
  // counter width, holds the longest period
  localparam int CW = 26;
  // power-on reset delays
  localparam int POR_T0_MS = 50;
  localparam int POR_T1_MS = 200;
  localparam int POR_T2_MS = 400;
  localparam int POR_T3_MS = 800;
  localparam int POR_C0 = POR_T0_MS * CYC_PER_MS;
  localparam int POR_C1 = POR_T1_MS * CYC_PER_MS;
  localparam int POR_C2 = POR_T2_MS * CYC_PER_MS;
  localparam int POR_C3 = POR_T3_MS * CYC_PER_MS;
  // watchdog periods
  localparam real WD_P0_S = 1.4;
  localparam int WD_P1_MS = 200;
  localparam int WD_P2_MS = 25;
  localparam int WD_C0 = int'(WD_P0_S * CLK_HZ);
  localparam int WD_C1 = WD_P1_MS * CYC_PER_MS;
  localparam int WD_C2 = WD_P2_MS * CYC_PER_MS;
  localparam logic [1:0] WD_SEL_P2 = 2'h2;
  localparam logic [1:0] WD_SEL_OFF = 2'h3;
  // watchdog fault hold, typical values
  localparam int WD_T1_MS = 200;
  localparam int WD_T2_MS = 25;
  localparam int WD_T1_C = WD_T1_MS * CYC_PER_MS;
  localparam int WD_T2_C = WD_T2_MS * CYC_PER_MS;
  // restart pulse width
  localparam int RSP_US = 1;
  localparam int RSP_CYC = RSP_US * CYC_PER_US;
  // nonvolatile write cycle
  localparam int NVW_TYP_MS = 5;
  localparam int NVW_MAX_MS = 10;
  localparam int NVW_C = NVW_TYP_MS * CYC_PER_MS;
  localparam int NVW_MAX_C = NVW_MAX_MS * CYC_PER_MS;
  // glitch suppression, least time rounded up
  localparam int GLITCH_NS = 50;
  localparam int GLITCH_CYC = (GLITCH_NS + CLK_PER_NS - 1) / CLK_PER_NS;
  // supply fall response, longest time rounded down
  localparam int TRP_US = 5;
  localparam int TRP_CYC = TRP_US * CYC_PER_US;
  localparam int TRP_USED = 3;
  // threshold programming sequence
  localparam int VPS_US = 10;
  localparam int VPH_US = 10;
  localparam int PRG_MS = 10;
  localparam int VPO_MS = 1;
  localparam int VPS_C = VPS_US * CYC_PER_US;
  localparam int VPH_C = VPH_US * CYC_PER_US;
  localparam int PRG_C = PRG_MS * CYC_PER_MS;
  localparam int VPO_C = VPO_MS * CYC_PER_MS;
  // synchroniser reset: bus lines idle high
  localparam logic [4:0] SYNC_RST = 5'h03;
  // host register map
  localparam int AW = 8;
  localparam logic [7:0] RG_CTRL = 8'h00;
  localparam logic [7:0] RG_BUS = 8'h04;
  localparam logic [7:0] RG_STAT = 8'h08;
  localparam logic [7:0] RG_MASK = 8'h0C;
  localparam logic [7:0] RG_LEVEL = 8'h10;
  // field positions
  localparam int CT_RST = 0;
  localparam int CT_PRG = 1;
  localparam int BUS_SCL = 0;
  localparam int BUS_SDA = 1;
  localparam int BUS_WRM = 2;
  localparam int NEV = 5;
  localparam logic [2:0] BUS_RST = 3'h3;
  // state machines
  typedef enum logic [2:0] {PR_HOLD = 3'h1, PR_DELAY = 3'h2, PR_RUN = 3'h4} stc_por_state_type;
  typedef enum logic [2:0] {WD_IDLE = 3'h1, WD_RUN = 3'h2, WD_FAULT = 3'h4} stc_wd_state_type;
  typedef enum logic [4:0] {
    PG_IDLE = 5'h01, PG_SETUP = 5'h02, PG_PROG = 5'h04, PG_HOLD = 5'h08, PG_OFF = 5'h10
  } stc_prog_state_type;
endpackage : stc_pkg

// >>> verification/stc_link_monitor.sv
`timescale 1ns/1ps
// timing checks on the host-device link
module stc_link_monitor #(
  parameter int P_PRG = 100,
  parameter int P_VPO = 50,
  parameter int P_WDT1 = 40,
  parameter int P_WDT2 = 20
) (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // link lines
  input wire logic wdog_restart,
  input wire logic prog_vp,
  input wire logic prog_strobe,
  input wire logic reset_out,
  input wire logic wdog_fault_out
);
  import stc_pkg::*;
  localparam int T_VP = 400; // 10 us of voltage around the action
  logic [3:0] lvl; // watched levels
  logic [3:0] prv_r; // levels one edge ago
  logic [15:0] run_r [4]; // edges since each level changed
  logic [15:0] run_nxt [4];
  assign lvl = {wdog_fault_out, prog_strobe, prog_vp, wdog_restart};
  // next run lengths, saturating
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (lvl[i] != prv_r[i]) begin
        run_nxt[i] = 16'h0001;
      end else begin
        run_nxt[i] = (run_r[i] == 16'hFFFF) ? run_r[i] : run_r[i] + 16'h0001;
      end
    end
  end
  // register runs; long runs at reset
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prv_r <= 4'h0;
      for (int i = 0; i < 4; i++) run_r[i] <= 16'hFFFF;
    end else begin
      prv_r <= lvl;
      run_r <= run_nxt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  // voltage standing long enough
  sequence s_vp_long;
    prog_vp && run_r[1] >= T_VP;
  endsequence
  property p_rsp_width; $fell(wdog_restart) |-> run_r[0] == 16'(RSP_CYC); endproperty
  a_rsp_width: assert property (p_rsp_width) else $error("restart pulse width wrong");
  property p_vp_setup; $rose(prog_strobe) |-> s_vp_long; endproperty
  a_vp_setup: assert property (p_vp_setup) else $error("voltage setup short");
  property p_vp_hold; $fell(prog_vp) |-> !prog_strobe && run_r[2] >= T_VP; endproperty
  a_vp_hold: assert property (p_vp_hold) else $error("voltage hold short");
  property p_strobe_in_vp; prog_strobe |-> prog_vp; endproperty
  a_strobe_in_vp: assert property (p_strobe_in_vp) else $error("action without voltage");
  property p_prog_len; $fell(prog_strobe) |-> run_r[2] >= P_PRG; endproperty
  a_prog_len: assert property (p_prog_len) else $error("program cycle short");
  property p_vp_off; $rose(prog_vp) |-> run_r[1] >= P_VPO; endproperty
  a_vp_off: assert property (p_vp_off) else $error("voltage off time short");
  property p_fault_hold;
    $fell(wdog_fault_out) |-> run_r[3] == P_WDT1 || run_r[3] == P_WDT2;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault hold wrong");
  property p_fault_quiet; $rose(wdog_fault_out) |-> !reset_out; endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("fault during reset");
endmodule : stc_link_monitor

// >>> verification/supervisor_timing_core_tb_top.sv
`timescale 1ns/1ps
module supervisor_timing_core_tb_top;
  import stc_pkg::*;
  logic clock, nrst; // clock and reset
  logic psel, penable, pwrite, pready, pslverr, irq; // apb
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic er;
  logic [3:0] sel; // por hi, lo, wdog hi, lo
  logic below, second, nv_req, nv_busy; // device side pins
  int num_errors, n_checks, n;
  // shortened counts shared by both ends, the monitor and the checks
  localparam int T_POR0 = 50, T_POR1 = 60, T_POR2 = 70, T_POR3 = 80; // power-on holds
  localparam int T_WD0 = 300, T_WD1 = 200, T_WD2 = 100; // watchdog periods
  localparam int T_WDT1 = 40, T_WDT2 = 20, T_NVW = 50; // fault holds, write time
  localparam int T_NVG = 60, T_PRG = 100, T_VPO = 50; // write guard, program, off time
  int por [4] = '{T_POR0, T_POR1, T_POR2, T_POR3};
  int per [3] = '{T_WD0, T_WD1, T_WD2};
  int hold [3] = '{T_WDT1, T_WDT1, T_WDT2};
  stc_link_if link();
  stc_device #(.P_POR0(T_POR0), .P_POR1(T_POR1), .P_POR2(T_POR2), .P_POR3(T_POR3),
    .P_WD0(T_WD0), .P_WD1(T_WD1), .P_WD2(T_WD2), .P_WDT1(T_WDT1), .P_WDT2(T_WDT2),
    .P_NVW(T_NVW)) u_stc_device (
    .clock(clock), .nrst(nrst), .link(link), .por_delay_sel_hi(sel[3]),
    .por_delay_sel_lo(sel[2]), .wdog_period_sel_hi(sel[1]), .wdog_period_sel_lo(sel[0]),
    .primary_below_trip(below), .second_supply_sense(second), .nv_write_req(nv_req),
    .nv_busy(nv_busy));
  stc_host #(.P_NVG(T_NVG), .P_PRG(T_PRG), .P_VPO(T_VPO)) u_stc_host (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(link));
  stc_link_monitor #(.P_PRG(T_PRG), .P_VPO(T_VPO), .P_WDT1(T_WDT1), .P_WDT2(T_WDT2))
    u_stc_link_monitor (
    .clock(clock), .nrst(nrst), .wdog_restart(link.wdog_restart), .prog_vp(link.prog_vp),
    .prog_strobe(link.prog_strobe), .reset_out(link.reset_out),
    .wdog_fault_out(link.wdog_fault_out));
  // compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, read data into rd
  task xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // wait for the answer; pready high ends this, else the hang guard
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  // edges until a level is seen
  task automatic cnt_until(ref logic s, input logic v, output int c);
    c = 0;
    while (s !== v) begin
      @(posedge clock);
      c++;
    end
  endtask : cnt_until
  // reset with new selectors
  task boot(input logic [3:0] s);
    @(posedge clock);
    nrst <= 1'b0;
    sel <= s;
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
  endtask : boot
  // counts, verdict, end of run
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict
  // bench clock
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // hang guard
  initial begin
    #(25 * 20000);
    num_errors++;
    give_verdict();
  end
  // test sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {below, second, nv_req, nrst} = '0;
    sel = 4'h3;
    for (int i = 0; i < 4; i++) begin
      boot({i[1:0], 2'h3});
      cnt_until(link.reset_out, 1'b0, n);
      chk(n >= por[i] && n <= por[i] + 3, 1);
    end
    xfer(1'b0, RG_BUS, 32'h0);
    chk(rd, 32'h3);
    $display("power-on test done");
    for (int i = 0; i < 3; i++) begin
      boot({2'h0, i[1:0]});
      cnt_until(link.reset_out, 1'b0, n);
      cnt_until(link.wdog_fault_out, 1'b1, n);
      chk(n >= per[i] - 2 && n <= per[i] + 3, 1);
      chk(irq, 0);
      cnt_until(link.wdog_fault_out, 1'b0, n);
      chk(n, hold[i]);
    end
    boot(4'h3);
    repeat (400) @(posedge clock);
    chk(link.wdog_fault_out, 0);
    $display("watchdog period test done");
    boot(4'h2);
    cnt_until(link.reset_out, 1'b0, n);
    xfer(1'b1, RG_MASK, 32'h2);
    repeat (40) @(posedge clock);
    xfer(1'b1, RG_CTRL, 32'h1);
    cnt_until(link.wdog_fault_out, 1'b1, n);
    chk(n > 100 && n <= 150, 1);
    repeat (3) @(posedge clock);
    chk(irq, 1);
    xfer(1'b0, RG_STAT, 32'h0);
    chk(rd[1], 1);
    xfer(1'b1, RG_STAT, 32'h2);
    repeat (2) @(posedge clock);
    chk(irq, 0);
    $display("restart test done");
    boot(4'h3);
    cnt_until(link.reset_out, 1'b0, n);
    @(posedge clock);
    below <= 1'b1;
    second <= 1'b1;
    cnt_until(link.reset_out, 1'b1, n);
    chk(n <= 200, 1);
    chk(link.second_supply_fail_out, 1);
    xfer(1'b0, RG_STAT, 32'h0);
    chk(rd[2:0], 32'h5);
    below <= 1'b0;
    second <= 1'b0;
    cnt_until(link.reset_out, 1'b0, n);
    $display("supply test done");
    nv_req <= 1'b1;
    xfer(1'b1, RG_BUS, 32'h1);
    xfer(1'b1, RG_BUS, 32'h7);
    cnt_until(nv_busy, 1'b1, n);
    chk(n <= 8, 1);
    xfer(1'b1, RG_BUS, 32'h3);
    xfer(1'b0, RG_BUS, 32'h0);
    chk(rd, 32'h7);
    cnt_until(nv_busy, 1'b0, n);
    chk(n >= 30 && n <= 50, 1);
    repeat (30) @(posedge clock);
    xfer(1'b1, RG_BUS, 32'h3);
    xfer(1'b0, RG_BUS, 32'h0);
    chk(rd, 32'h3);
    xfer(1'b1, RG_STAT, 32'h1F);
    $display("write cycle test done");
    xfer(1'b1, RG_CTRL, 32'h2);
    xfer(1'b1, RG_CTRL, 32'h2);
    repeat (440) @(posedge clock);
    chk(link.prog_strobe, 1);
    cnt_until(link.prog_vp, 1'b0, n);
    repeat (60) @(posedge clock);
    xfer(1'b0, RG_STAT, 32'h0);
    chk(rd[4:3], 32'h3);
    xfer(1'b0, 8'h14, 32'h0);
    chk(er, 1);
    chk(rd, 32'h0);
    $display("programming test done");
    give_verdict();
  end
endmodule : supervisor_timing_core_tb_top
